// file: adps_pkg.sv
// constants, field layout and code checks for the program select bank
// assumes a single 100 MHz clock domain shared by every user of the bank
package adps_pkg;

    localparam int unsigned REG_W = 8;
    localparam int unsigned REG_COUNT = 8;
    localparam int unsigned CODE_W = 5;

    typedef logic [CODE_W-1:0] adps_code_t;
    typedef logic [REG_W-1:0] adps_byte_t;

    // register offsets, the printed byte addresses
    localparam adps_byte_t OFS_RSVD_A = 8'h37;
    localparam adps_byte_t OFS_RSVD_B = 8'h38;
    localparam adps_byte_t OFS_RSVD_C = 8'h39;
    localparam adps_byte_t OFS_RSVD_D = 8'h3a;
    localparam adps_byte_t OFS_RSVD_E = 8'h3b;
    localparam adps_byte_t OFS_PLAY_SEL = 8'h3c;
    localparam adps_byte_t OFS_REC_SEL = 8'h3d;
    localparam adps_byte_t OFS_COND = 8'h3e;

    // values after reset; unknown bits come up as zero
    localparam adps_byte_t RST_RSVD_A = 8'h02;
    localparam adps_byte_t RST_RSVD_B = 8'h02;
    localparam adps_byte_t RST_RSVD_C = 8'h00;
    localparam adps_byte_t RST_RSVD_D = 8'h00;
    localparam adps_byte_t RST_RSVD_E = 8'h00;
    localparam adps_byte_t RST_PLAY_SEL = 8'h01;
    localparam adps_byte_t RST_REC_SEL = 8'h04;
    localparam adps_byte_t RST_COND = 8'h00;

    // field positions
    localparam int unsigned SEL_MSB = 4;
    localparam int unsigned COND_REC_A = 6;
    localparam int unsigned COND_REC_B = 5;
    localparam int unsigned COND_REC_HOLD = 4;
    localparam int unsigned COND_PLAY_A = 2;
    localparam int unsigned COND_PLAY_B = 1;
    localparam int unsigned COND_PLAY_HOLD = 0;
    localparam adps_byte_t SEL_RSVD_MASK = 8'he0;
    localparam adps_byte_t COND_RSVD_MASK = 8'h88;

    // playback codes
    localparam adps_code_t PLAY_FIRST = 5'h01;
    localparam adps_code_t PLAY_LAST = 5'h19;

    // engine index inside the per-engine arrays
    localparam int unsigned ENG_PLAY = 0;
    localparam int unsigned ENG_REC = 1;
    localparam int unsigned ENG_COUNT = 2;

    function automatic logic playLegal(input adps_code_t c);
        return (c >= PLAY_FIRST) && (c <= PLAY_LAST);
    endfunction

    function automatic logic recLegal(input adps_code_t c);
        logic ok;
        ok = 1'b0;
        unique case (c)
            5'h04, 5'h05, 5'h06: ok = 1'b1;
            5'h0a, 5'h0b, 5'h0c: ok = 1'b1;
            5'h10, 5'h11, 5'h12: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

endpackage

// file: adps_sel_if.sv
// carries the live engine settings from the register bank to the engine control
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface adps_sel_if;
    logic [adps_pkg::ENG_COUNT-1:0] holdCounter;
    logic [adps_pkg::ENG_COUNT-1:0] frameStart;
    logic [adps_pkg::ENG_COUNT-1:0] counterRestart;

    modport bank
    (
        output holdCounter,
        output frameStart,
        input counterRestart
    );

    modport engine
    (
        input holdCounter,
        input frameStart,
        output counterRestart
    );
endinterface

// file: adps_engine_ctrl.sv
// frame restart gating of the two instruction counters
// assumes frame start pulses are one cycle wide and on the bank clock
`timescale 1ns/1ps
module adps_engine_ctrl
(
    input wire logic clock,
    input wire logic rst,
    adps_sel_if.engine sel
);

    logic [adps_pkg::ENG_COUNT-1:0] restart_d;
    logic [adps_pkg::ENG_COUNT-1:0] restart_q;

    genvar g;
    generate
        for (g = 0; g < adps_pkg::ENG_COUNT; g++)
        begin : gEngine
            // clear bit restarts on every frame, set bit keeps the count
            assign restart_d[g] = sel.frameStart[g] & ~sel.holdCounter[g];
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            restart_q <= '0;
        end
        else
        begin
            restart_q <= restart_d;
        end
    end

    assign sel.counterRestart = restart_q;

    a_rec_restart: assert property (@(posedge clock) disable iff (rst)
        sel.frameStart[adps_pkg::ENG_REC] |=>
        sel.counterRestart[adps_pkg::ENG_REC] == !$past(sel.holdCounter[adps_pkg::ENG_REC]))
        else $error("record counter restart wrong");

    a_play_restart: assert property (@(posedge clock) disable iff (rst)
        !sel.frameStart[adps_pkg::ENG_PLAY] |=> !sel.counterRestart[adps_pkg::ENG_PLAY])
        else $error("playback restart without frame");

    a_play_restart_on: assert property (@(posedge clock) disable iff (rst)
        sel.frameStart[adps_pkg::ENG_PLAY] && !sel.holdCounter[adps_pkg::ENG_PLAY]
        |=> sel.counterRestart[adps_pkg::ENG_PLAY])
        else $error("playback restart missing");

    c_rec_held: cover property (@(posedge clock) disable iff (rst)
        sel.frameStart[adps_pkg::ENG_REC] && sel.holdCounter[adps_pkg::ENG_REC]);

endmodule

// file: adps_regs.sv
// program select and condition bit register bank for the two processing engines
// assumes a simple same-clock register port driven by the control interface logic
//
// What this block does
// - the playback field selects playback program n for code n from 1 to 25, reset code 1.
// - record codes 4, 5 and 6 select record programs four to six, reset code 4.
// - record codes 10 and 12 select programs ten and twelve, code 11 is also accepted.
// - record codes 16, 17 and 18 select record programs sixteen to eighteen.
// - record condition bits A at bit 6 and B at bit 5 are writable and reset to zero.
// - record bit 4 clear restarts its counter each frame, set keeps it.
// - playback condition bits A at bit 2 and B at bit 1 are writable and reset to zero.
// - playback bit 0 clear restarts its counter each frame, set keeps it.
`timescale 1ns/1ps
module adps_regs
(
    input wire logic clock,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regAck,
    input wire logic playFrameStart,
    input wire logic recFrameStart,
    output logic [4:0] playbackProgram,
    output logic [4:0] recordProgram,
    output logic playCondA,
    output logic playCondB,
    output logic recCondA,
    output logic recCondB,
    output logic playHoldCounter,
    output logic recHoldCounter,
    output logic playCounterRestart,
    output logic recCounterRestart,
    output logic softwareFault
);

    typedef adps_pkg::adps_byte_t adps_file_t [adps_pkg::REG_COUNT];

    localparam adps_file_t RESET_FILE = '{
        adps_pkg::RST_RSVD_A,
        adps_pkg::RST_RSVD_B,
        adps_pkg::RST_RSVD_C,
        adps_pkg::RST_RSVD_D,
        adps_pkg::RST_RSVD_E,
        adps_pkg::RST_PLAY_SEL,
        adps_pkg::RST_REC_SEL,
        adps_pkg::RST_COND
    };

    localparam logic [2:0] IDX_RSVD_E = 3'h4;
    localparam logic [2:0] IDX_PLAY = 3'h5;
    localparam logic [2:0] IDX_REC = 3'h6;
    localparam logic [2:0] IDX_COND = 3'h7;

    // the index decode is three bits wide, so the bank cannot grow past eight
    if (adps_pkg::REG_COUNT != 8)
    begin : gBadCount
        $error("bank decode serves exactly eight registers");
    end

    // address decode, used by the write path and the read path
    function automatic logic isMapped(input logic [7:0] a);
        return (a >= adps_pkg::OFS_RSVD_A) && (a <= adps_pkg::OFS_COND);
    endfunction

    function automatic logic [2:0] regIdx(input logic [7:0] a);
        logic [7:0] diff;
        diff = a - adps_pkg::OFS_RSVD_A;
        return diff[2:0];
    endfunction

    adps_file_t file_d;
    adps_file_t file_q;
    adps_pkg::adps_code_t playCode_d;
    adps_pkg::adps_code_t playCode_q;
    adps_pkg::adps_code_t recCode_d;
    adps_pkg::adps_code_t recCode_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic ack_d;
    logic ack_q;
    logic fault_d;
    logic fault_q;
    logic wrHit;
    logic [2:0] wrIdx;
    adps_pkg::adps_code_t wrCode;

    adps_sel_if sel();

    assign wrHit = regWrite && isMapped(regAddr);
    assign wrIdx = regIdx(regAddr);
    assign wrCode = regWdata[adps_pkg::SEL_MSB:0];

    // register file: every bit stored, so reads return the last write
    always_comb
    begin
        file_d = file_q;
        if (wrHit)
        begin
            file_d[wrIdx] = regWdata;
        end
    end

    // the engines only ever see a legal program; a reserved code is stored
    // for readback but leaves the running program unchanged, since a bad
    // code would otherwise start an engine on an undefined program
    always_comb
    begin
        playCode_d = playCode_q;
        recCode_d = recCode_q;
        if (wrHit && (wrIdx == IDX_PLAY) && adps_pkg::playLegal(wrCode))
        begin
            playCode_d = wrCode;
        end
        if (wrHit && (wrIdx == IDX_REC) && adps_pkg::recLegal(wrCode))
        begin
            recCode_d = wrCode;
        end
    end

    // fault pulse when software breaks a write restriction
    always_comb
    begin
        fault_d = 1'b0;
        if (wrHit)
        begin
            unique case (wrIdx)
                IDX_PLAY:
                begin
                    fault_d = !adps_pkg::playLegal(wrCode) ||
                        ((regWdata & adps_pkg::SEL_RSVD_MASK) != 8'h00);
                end
                IDX_REC:
                begin
                    fault_d = !adps_pkg::recLegal(wrCode) ||
                        ((regWdata & adps_pkg::SEL_RSVD_MASK) != 8'h00);
                end
                IDX_RSVD_E:
                begin
                    fault_d = (regWdata != 8'h00);
                end
                default:
                begin
                    fault_d = 1'b0;
                end
            endcase
        end
    end

    // read path: one cycle answer, unmapped reads return zero
    always_comb
    begin
        ack_d = regWrite || regRead;
        rdata_d = rdata_q;
        if (regRead)
        begin
            if (isMapped(regAddr))
            begin
                rdata_d = file_q[regIdx(regAddr)];
            end
            else
            begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            file_q <= RESET_FILE;
            playCode_q <= adps_pkg::RST_PLAY_SEL[adps_pkg::SEL_MSB:0];
            recCode_q <= adps_pkg::RST_REC_SEL[adps_pkg::SEL_MSB:0];
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
            fault_q <= 1'b0;
        end
        else
        begin
            file_q <= file_d;
            playCode_q <= playCode_d;
            recCode_q <= recCode_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            fault_q <= fault_d;
        end
    end

    assign sel.holdCounter[adps_pkg::ENG_PLAY] = file_q[IDX_COND][adps_pkg::COND_PLAY_HOLD];
    assign sel.holdCounter[adps_pkg::ENG_REC] = file_q[IDX_COND][adps_pkg::COND_REC_HOLD];
    assign sel.frameStart[adps_pkg::ENG_PLAY] = playFrameStart;
    assign sel.frameStart[adps_pkg::ENG_REC] = recFrameStart;

    adps_engine_ctrl uEngine
    (
        .clock(clock),
        .rst(rst),
        .sel(sel.engine)
    );

    assign regRdata = rdata_q;
    assign regAck = ack_q;
    assign softwareFault = fault_q;
    assign playbackProgram = playCode_q;
    assign recordProgram = recCode_q;
    assign playCondA = file_q[IDX_COND][adps_pkg::COND_PLAY_A];
    assign playCondB = file_q[IDX_COND][adps_pkg::COND_PLAY_B];
    assign recCondA = file_q[IDX_COND][adps_pkg::COND_REC_A];
    assign recCondB = file_q[IDX_COND][adps_pkg::COND_REC_B];
    assign playHoldCounter = file_q[IDX_COND][adps_pkg::COND_PLAY_HOLD];
    assign recHoldCounter = file_q[IDX_COND][adps_pkg::COND_REC_HOLD];
    assign playCounterRestart = sel.counterRestart[adps_pkg::ENG_PLAY];
    assign recCounterRestart = sel.counterRestart[adps_pkg::ENG_REC];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_play_reset_code: assert property (
        $fell(rst) |-> playbackProgram == 5'h01 && recordProgram == 5'h04)
        else $error("program select reset codes wrong");

    a_play_follow: assert property (
        regWrite && regAddr == adps_pkg::OFS_PLAY_SEL && adps_pkg::playLegal(regWdata[4:0])
        |=> playbackProgram == $past(regWdata[4:0]))
        else $error("playback program did not follow write");

    a_play_hold_bad: assert property (
        regWrite && regAddr == adps_pkg::OFS_PLAY_SEL && !adps_pkg::playLegal(regWdata[4:0])
        |=> $stable(playbackProgram) ##0 softwareFault)
        else $error("reserved playback code reached engine");

    a_rec_low_codes: assert property (
        regWrite && regAddr == adps_pkg::OFS_REC_SEL &&
        regWdata[4:0] >= 5'h04 && regWdata[4:0] <= 5'h06
        |=> recordProgram == $past(regWdata[4:0]))
        else $error("record program four to six wrong");

    a_rec_mid_codes: assert property (
        regWrite && regAddr == adps_pkg::OFS_REC_SEL &&
        (regWdata[4:0] == 5'h0a || regWdata[4:0] == 5'h0c)
        |=> recordProgram == $past(regWdata[4:0]))
        else $error("record program ten or twelve wrong");

    a_rec_high_codes: assert property (
        regWrite && regAddr == adps_pkg::OFS_REC_SEL &&
        regWdata[4:0] >= 5'h10 && regWdata[4:0] <= 5'h12
        |=> recordProgram == $past(regWdata[4:0]))
        else $error("record program sixteen to eighteen wrong");

    a_rec_hold_bad: assert property (
        regWrite && regAddr == adps_pkg::OFS_REC_SEL && !adps_pkg::recLegal(regWdata[4:0])
        |=> $stable(recordProgram) ##0 softwareFault)
        else $error("reserved record code reached engine");

    a_cond_bits: assert property (
        regWrite && regAddr == adps_pkg::OFS_COND
        |=> recCondA == $past(regWdata[6]) && recCondB == $past(regWdata[5]) &&
            playCondA == $past(regWdata[2]) && playCondB == $past(regWdata[1]))
        else $error("condition bits did not follow write");

    a_hold_bits: assert property (
        regWrite && regAddr == adps_pkg::OFS_COND
        |=> recHoldCounter == $past(regWdata[4]) && playHoldCounter == $past(regWdata[0]))
        else $error("counter hold bits did not follow write");

    a_rsvd_zero_fault: assert property (
        regWrite && regAddr == adps_pkg::OFS_RSVD_E && regWdata != 8'h00 |=> softwareFault)
        else $error("nonzero reserved write not flagged");

    a_readback: assert property (
        regWrite && isMapped(regAddr) ##1 regRead && !regWrite && regAddr == $past(regAddr)
        |=> regRdata == $past(regWdata, 2) ##0 regAck)
        else $error("readback differs from last write");

    c_play_last: cover property (
        regWrite && regAddr == adps_pkg::OFS_PLAY_SEL && regWdata == 8'h19);
    c_rec_twelve: cover property (
        regWrite && regAddr == adps_pkg::OFS_REC_SEL && regWdata == 8'h0c);
    c_cond_all: cover property (
        regWrite && regAddr == adps_pkg::OFS_COND && regWdata == 8'h77);
    c_fault: cover property (softwareFault);

endmodule

// file: tb_audio_dsp_program_select_regs.sv
// self-checking bench for the program select and condition bit register bank
// assumes adps_regs and adps_pkg are compiled first; one 100 MHz clock
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_audio_dsp_program_select_regs;
    logic clock;
    logic rst;
    logic regWrite;
    logic regRead;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic regAck;
    logic playFrameStart;
    logic recFrameStart;
    logic [4:0] playbackProgram;
    logic [4:0] recordProgram;
    logic playCondA, playCondB, recCondA, recCondB;
    logic playHoldCounter, recHoldCounter;
    logic playCounterRestart, recCounterRestart;
    logic softwareFault;
    int err_count = 0;
    int total_checks = 0;
    logic [4:0] expProg;
    logic [7:0] v;
    logic fault;
    logic ps, rs;

    adps_regs u_adps_regs
    (
        .clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
        .playFrameStart(playFrameStart), .recFrameStart(recFrameStart),
        .playbackProgram(playbackProgram), .recordProgram(recordProgram),
        .playCondA(playCondA), .playCondB(playCondB), .recCondA(recCondA),
        .recCondB(recCondB), .playHoldCounter(playHoldCounter),
        .recHoldCounter(recHoldCounter), .playCounterRestart(playCounterRestart),
        .recCounterRestart(recCounterRestart), .softwareFault(softwareFault)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic playOk(input int c);
        return c >= 1 && c <= 25;
    endfunction

    function automatic logic recOk(input int c);
        return c inside {4, 5, 6, 10, 11, 12, 16, 17, 18};
    endfunction

    task automatic end_of_test();
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one write; the strobe stays up until the next task or the caller lowers it,
    // so no strobe is dropped and raised again in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regRead = 1'b0;
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge clock);
        #1;
        `CHK(regAck, 1'b1)
    endtask

    // bits where mask is 0 are left out of the compare, though reset defines them all
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        regWrite = 1'b0;
        regRead = 1'b1;
        regAddr = a;
        @(posedge clock);
        #1;
        `CHK(regAck, 1'b1)
        `CHK(regRdata & m, e & m)
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        rst = 1'b0;
    endtask

    initial
    begin
        #50000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        playFrameStart = 1'b0;
        recFrameStart = 1'b0;
        void'($urandom(47717));
        do_reset();
        `CHK(playbackProgram, 5'h01)
        `CHK(recordProgram, 5'h04)
        `CHK({recCondA, recCondB, playCondA, playCondB}, 4'h0)
        rd(8'h37, 8'h02, 8'hff);
        rd(8'h38, 8'h02, 8'hfe);
        rd(8'h39, 8'h00, 8'hee);
        rd(8'h3a, 8'h00, 8'hef);
        rd(8'h3b, 8'h00, 8'hff);
        rd(8'h3c, 8'h01, 8'hff);
        rd(8'h3d, 8'h04, 8'hff);
        rd(8'h3e, 8'h00, 8'hff);
        // every playback code, reserved ones must leave the program alone
        expProg = 5'h01;
        for (int c = 0; c < 32; c++)
        begin
            fault = !playOk(c);
            wr(8'h3c, 8'(c));
            if (!fault)
                expProg = 5'(c);
            `CHK(playbackProgram, expProg)
            `CHK(softwareFault, fault)
            rd(8'h3c, 8'(c), 8'hff);
        end
        // reserved upper bits are flagged, but the legal code field still takes effect
        wr(8'h3c, 8'h25);
        `CHK(softwareFault, 1'b1)
        `CHK(playbackProgram, 5'h05)
        // record codes walked from the top down, so reserved codes 3 to 0 are reached last
        expProg = 5'h04;
        for (int c = 31; c >= 0; c--)
        begin
            fault = !recOk(c);
            wr(8'h3d, 8'(c));
            if (!fault)
                expProg = 5'(c);
            `CHK(recordProgram, expProg)
            `CHK(softwareFault, fault)
            rd(8'h3d, 8'(c), 8'hff);
        end
        wr(8'h3d, 8'hc5);
        `CHK(softwareFault, 1'b1)
        `CHK(recordProgram, 5'h05)
        // condition bits and frame restarts with random settings
        for (int i = 0; i < 24; i++)
        begin
            v = (i == 0) ? 8'h77 : (i == 1) ? 8'h00 : 8'($urandom);
            wr(8'h3e, v);
            `CHK({recCondA, recCondB}, v[6:5])
            `CHK({playCondA, playCondB}, v[2:1])
            `CHK({recHoldCounter, playHoldCounter}, {v[4], v[0]})
            rd(8'h3e, v, 8'hff);
            ps = 1'($urandom);
            rs = 1'($urandom);
            regRead = 1'b0;
            playFrameStart = ps;
            recFrameStart = rs;
            @(posedge clock);
            #1;
            playFrameStart = 1'b0;
            recFrameStart = 1'b0;
            `CHK(playCounterRestart, ps & ~v[0])
            `CHK(recCounterRestart, rs & ~v[4])
            @(posedge clock);
            #1;
            `CHK({playCounterRestart, recCounterRestart}, 2'b00)
        end
        // reserved registers keep whatever was written; 0x3b wants zeros only
        for (int a = 8'h37; a <= 8'h3a; a++)
        begin
            v = 8'($urandom);
            wr(8'(a), v);
            rd(8'(a), v, 8'hff);
        end
        wr(8'h3b, 8'h00);
        `CHK(softwareFault, 1'b0)
        wr(8'h3b, 8'h5a);
        `CHK(softwareFault, 1'b1)
        rd(8'h3b, 8'h5a, 8'hff);
        // unmapped places answer but hold nothing
        wr(8'h40, 8'($urandom));
        rd(8'h40, 8'h00, 8'hff);
        wr(8'h36, 8'hff);
        rd(8'h36, 8'h00, 8'hff);
        // a second reset in mid-run restores the defaults
        do_reset();
        rd(8'h3c, 8'h01, 8'hff);
        rd(8'h3d, 8'h04, 8'hff);
        rd(8'h3e, 8'h00, 8'hff);
        end_of_test();
    end
endmodule
